// ==== pwmc_defs.vh ====
`ifndef PWMC_DEFS_VH
`define PWMC_DEFS_VH
`define PWMC_ADDR_W 3
`define PWMC_ADDR_CONTROL 3'h0
`define PWMC_ADDR_DUTY_HIGH 3'h1
`define PWMC_ADDR_DUTY_LOW 3'h2
`define PWMC_ADDR_PERIOD 3'h3
`define PWMC_ADDR_TIMER 3'h4
`define PWMC_ADDR_TIMER_CTRL 3'h5
`define PWMC_BIT_ENABLE 7
`define PWMC_BIT_LEVEL 5
`define PWMC_BIT_POLARITY 4
`define PWMC_BIT_TMR_ON 7
`define PWMC_BIT_SLEEP 6
`define PWMC_PRESC_LSB 0
`define PWMC_CONTROL_RESET 8'h00
`define PWMC_PERIOD_RESET 8'hff
`define PWMC_TIMER_RESET 8'h00
`define PWMC_TCTRL_RESET 8'h00
`endif

// ==== pwmc_regs.v ====
`timescale 1ns/1ps
`include "pwmc_defs.vh"
// duty-cycle storage; no reset so contents survive every reset type
module pwmc_regs
(
    input wire mclk,
    input wire wr_high,
    input wire wr_low,
    input wire [7:0] wdata,
    output reg [7:0] duty_high_q,
    output reg [1:0] duty_low_q
);
    always @(posedge mclk)
    begin
        if (wr_high)
            duty_high_q <= wdata;
        if (wr_low)
            duty_low_q <= wdata[7:6];
    end
endmodule

// ==== pwmc_timebase.v ====
`timescale 1ns/1ps
`include "pwmc_defs.vh"
// 8-bit timer with 2-bit sub-count giving a 10-bit time base
module pwmc_timebase
(
    input wire mclk,
    input wire reset_n,
    input wire run,
    input wire [1:0] presc_sel,
    input wire [7:0] period_value,
    input wire tmr_wr,
    input wire [7:0] wdata,
    output reg [7:0] time_base_counter_q,
    output reg [1:0] sub_q,
    output reg period_end_q
);
    reg [5:0] presc_q;
    function [5:0] presc_max;
        input [1:0] sel;
        begin
            case (sel)
                2'h0: presc_max = 6'h00;
                2'h1: presc_max = 6'h03;
                2'h2: presc_max = 6'h0f;
                default: presc_max = 6'h3f;
            endcase
        end
    endfunction
    wire presc_done = (presc_q >= presc_max(presc_sel));
    wire inc = run && presc_done && (sub_q == 2'h3);
    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            time_base_counter_q <= `PWMC_TIMER_RESET;
            sub_q <= 2'h0;
            presc_q <= 6'h00;
            period_end_q <= 1'b0;
        end
        else
        begin
            period_end_q <= 1'b0;
            if (tmr_wr)
            begin
                time_base_counter_q <= wdata;
                sub_q <= 2'h0;
                presc_q <= 6'h00;
            end
            else if (run)
            begin
                presc_q <= presc_done ? 6'h00 : presc_q + 6'h01;
                if (presc_done)
                    sub_q <= sub_q + 2'h1;
                if (inc)
                begin
                    if (time_base_counter_q == period_value)
                    begin
                        time_base_counter_q <= 8'h00;
                        period_end_q <= 1'b1;
                    end
                    else
                        time_base_counter_q <= time_base_counter_q + 8'h01;
                end
            end
        end
    end
endmodule

// ==== pwmc_top.v ====
// What this block does
// - control bit 7 enables waveform generation
// - control bit 5 reads the waveform's active state before polarity is applied, read-only
// - control bit 4 selects active-low output
// - duty-high register holds duty bits 9..2
// - duty-low bits 7..6 hold duty bits 1..0
// - unused bits read zero, ignore writes
// - control clears on reset; duty kept
// - period end clears timer, sets output unless duty is zero, latches duty
// - disabled output sits at default level
// - time base is timer plus two sub bits
// - sleep freezes timer and module state; control writes still change the output
`timescale 1ns/1ps
`include "pwmc_defs.vh"
module pwmc_top
(
    input wire mclk,
    input wire reset_n,
    input wire [2:0] addr,
    input wire [7:0] wdata,
    input wire wr_en,
    input wire rd_en,
    input wire sleep_req,
    output reg [7:0] rdata_q,
    output reg pwm_out_q
);
    reg enable_q;
    reg polarity_q;
    reg [7:0] period_q;
    reg tmr_on_q;
    reg [1:0] presc_sel_q;
    reg sleep_s1_q;
    reg sleep_s2_q;
    reg [9:0] duty_latched_q;
    reg active_q;
    reg active_d;
    reg [7:0] rdata_d;
    wire [7:0] duty_high_q;
    wire [1:0] duty_low_q;
    wire [7:0] tmr_q;
    wire [1:0] sub_q;
    wire period_end;
    wire [9:0] duty_cycle_value = {duty_high_q, duty_low_q};
    wire [9:0] time_base = {tmr_q, sub_q};
    wire asleep = sleep_s2_q;
    wire wr_ctrl = wr_en && (addr == `PWMC_ADDR_CONTROL);
    wire wr_tmr = wr_en && (addr == `PWMC_ADDR_TIMER) && !asleep;

    pwmc_regs u_regs
    (
        .mclk(mclk),
        .wr_high(wr_en && (addr == `PWMC_ADDR_DUTY_HIGH)),
        .wr_low(wr_en && (addr == `PWMC_ADDR_DUTY_LOW)),
        .wdata(wdata),
        .duty_high_q(duty_high_q),
        .duty_low_q(duty_low_q)
    );

    pwmc_timebase u_tb
    (
        .mclk(mclk),
        .reset_n(reset_n),
        .run(tmr_on_q && !asleep),
        .presc_sel(presc_sel_q),
        .period_value(period_q),
        .tmr_wr(wr_tmr),
        .wdata(wdata),
        .time_base_counter_q(tmr_q),
        .sub_q(sub_q),
        .period_end_q(period_end)
    );

    // sleep request is asynchronous to mclk
    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sleep_s1_q <= 1'b0;
            sleep_s2_q <= 1'b0;
        end
        else
        begin
            sleep_s1_q <= sleep_req;
            sleep_s2_q <= sleep_s1_q;
        end
    end

    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            enable_q <= 1'b0;
            polarity_q <= 1'b0;
            period_q <= `PWMC_PERIOD_RESET;
            tmr_on_q <= 1'b0;
            presc_sel_q <= 2'h0;
        end
        else
        begin
            if (wr_ctrl)
            begin
                enable_q <= wdata[`PWMC_BIT_ENABLE];
                polarity_q <= wdata[`PWMC_BIT_POLARITY];
            end
            if (wr_en && (addr == `PWMC_ADDR_PERIOD))
                period_q <= wdata;
            if (wr_en && (addr == `PWMC_ADDR_TIMER_CTRL))
            begin
                tmr_on_q <= wdata[`PWMC_BIT_TMR_ON];
                presc_sel_q <= wdata[`PWMC_PRESC_LSB+1:`PWMC_PRESC_LSB];
            end
        end
    end

    // duty waveform; duty above the period keeps the output active
    always @*
    begin
        active_d = active_q;
        if (!enable_q)
            active_d = 1'b0;
        else if (asleep)
            active_d = active_q;
        else if (period_end)
            active_d = (duty_cycle_value != 10'h000);
        else if (time_base == duty_latched_q)
            active_d = 1'b0;
    end

    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            active_q <= 1'b0;
            duty_latched_q <= 10'h000;
            pwm_out_q <= 1'b0;
        end
        else
        begin
            active_q <= active_d;
            if (period_end && !asleep)
                duty_latched_q <= duty_cycle_value;
            pwm_out_q <= active_d ^ polarity_q;
        end
    end

    always @*
    begin
        rdata_d = 8'h00;
        case (addr)
            `PWMC_ADDR_CONTROL:
            begin
                rdata_d[`PWMC_BIT_ENABLE] = enable_q;
                rdata_d[`PWMC_BIT_LEVEL] = active_q;
                rdata_d[`PWMC_BIT_POLARITY] = polarity_q;
            end
            `PWMC_ADDR_DUTY_HIGH: rdata_d = duty_high_q;
            `PWMC_ADDR_DUTY_LOW: rdata_d = {duty_low_q, 6'h00};
            `PWMC_ADDR_PERIOD: rdata_d = period_q;
            `PWMC_ADDR_TIMER: rdata_d = tmr_q;
            `PWMC_ADDR_TIMER_CTRL:
                rdata_d = {tmr_on_q, asleep, 4'h0, presc_sel_q};
            default: rdata_d = 8'h00;
        endcase
    end

    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            rdata_q <= 8'h00;
        else if (rd_en)
            rdata_q <= rdata_d;
        else
            rdata_q <= 8'h00;
    end
endmodule

// ==== pwmc_properties.sv ====
`timescale 1ns/1ps
module pwmc_props
(
    input wire mclk,
    input wire reset_n,
    input wire [2:0] addr,
    input wire [7:0] wdata,
    input wire wr_en,
    input wire rd_en,
    input wire sleep_req,
    input wire [7:0] rdata_q,
    input wire pwm_out_q
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    a_read_idle: assert property (!rd_en |=> rdata_q == 8'h00)
        else $error("read data not idle");
    a_ctrl_unused: assert property (rd_en && addr == 3'h0 |=>
        (rdata_q & 8'h4f) == 8'h00) else $error("control unused set");
    a_low_unused: assert property (rd_en && addr == 3'h2 |=>
        rdata_q[5:0] == 6'h00) else $error("duty low unused set");
    a_enable_back: assert property (wr_en && addr == 3'h0 ##1 !wr_en
        ##1 rd_en && addr == 3'h0 |=> rdata_q[7] == $past(wdata[7], 3))
        else $error("enable readback wrong");
    a_polarity_back: assert property (wr_en && addr == 3'h0 ##1
        !wr_en ##1 rd_en && addr == 3'h0 |=>
        rdata_q[4] == $past(wdata[4], 3)) else $error("polarity wrong");
    a_duty_high: assert property (wr_en && addr == 3'h1 ##1 !wr_en
        ##1 rd_en && addr == 3'h1 |=> rdata_q == $past(wdata, 3))
        else $error("duty high readback wrong");
    a_duty_low: assert property (wr_en && addr == 3'h2 ##1 !wr_en
        ##1 rd_en && addr == 3'h2 |=> rdata_q[7:6] == $past(wdata[7:6], 3))
        else $error("duty low readback wrong");
    a_disabled_pin: assert property (wr_en && addr == 3'h0 &&
        !wdata[7] && !sleep_req ##1 (!wr_en && !sleep_req) [*3] |->
        pwm_out_q == $past(wdata[4], 3)) else $error("idle level wrong");
    c_read: cover property (rd_en && addr == 3'h0);
    c_pulse: cover property (pwm_out_q ##1 !pwm_out_q);
    c_sleep: cover property (sleep_req [*8]);
endmodule
bind pwmc_top pwmc_props u_props (.mclk(mclk), .reset_n(reset_n),
    .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .sleep_req(sleep_req), .rdata_q(rdata_q), .pwm_out_q(pwm_out_q));

// ==== pwmc_load.sv ====
`timescale 1ns/1ps
// load stage: measures period and high time between rising pin edges
module pwmc_load
(
    input wire mclk,
    input wire pin,
    output reg [7:0] per_q = 8'h00,
    output reg [7:0] hi_q = 8'h00
);
    reg [7:0] per_c = 8'h00;
    reg [7:0] hi_c = 8'h00;
    reg pin_q = 1'b0;
    always @(posedge mclk)
    begin
        pin_q <= pin;
        per_c <= (pin && !pin_q) ? 8'h01 : per_c + 8'h01;
        hi_c <= (pin && !pin_q) ? 8'h01 : hi_c + {7'h00, pin};
        if (pin && !pin_q)
        begin
            per_q <= per_c;
            hi_q <= hi_c;
        end
    end
endmodule

// ==== pwm_control_duty_regs_bench.sv ====
`timescale 1ns/1ps
module pwm_control_duty_regs_bench;
    reg mclk = 1'b0;
    reg reset_n = 1'b0;
    reg [2:0] addr = 3'h0;
    reg [7:0] wdata = 8'h00;
    reg wr_en = 1'b0;
    reg rd_en = 1'b0;
    reg sleep_req = 1'b0;
    reg [7:0] v;
    reg [7:0] t;
    wire [7:0] rdata_q;
    wire pwm_out_q;
    wire [7:0] per_q;
    wire [7:0] hi_q;
    integer num_errors = 0;
    integer checked = 0;
    pwmc_top uut (.mclk(mclk), .reset_n(reset_n), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
        .sleep_req(sleep_req), .rdata_q(rdata_q), .pwm_out_q(pwm_out_q));
    pwmc_load ld (.mclk(mclk), .pin(pwm_out_q), .per_q(per_q), .hi_q(hi_q));
    initial
    begin
        forever #5 mclk = ~mclk;
    end
    task w(input [2:0] a, input [7:0] d);
    begin
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge mclk);
        wr_en <= 1'b0;
    end
    endtask
    // read data stand only in the cycle after the strobe
    task r(input [2:0] a);
    begin
        @(posedge mclk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge mclk);
        rd_en <= 1'b0;
        #1;
        v = rdata_q;
    end
    endtask
    task chk(input [7:0] got, input [7:0] exp);
    begin
        checked = checked + 1;
        if (got !== exp)
        begin
            num_errors = num_errors + 1;
            $display("unexpected at %0t: %h vs %h", $time, got, exp);
        end
    end
    endtask
    task finish_test;
    begin
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    end
    endtask
    initial
    begin
        #200000;
        num_errors = num_errors + 1;
        finish_test;
    end
    initial
    begin
        repeat (8) @(posedge mclk);
        reset_n <= 1'b1;
        r(3'h0);
        chk(v, 8'h00);
        w(3'h0, 8'h7f);
        r(3'h0);
        chk(v, 8'h10);
        chk({7'h00, pwm_out_q}, 8'h01);
        w(3'h1, 8'h01);
        w(3'h2, 8'hbf);
        r(3'h2);
        chk(v, 8'h80);
        r(3'h1);
        chk(v, 8'h01);
        r(3'h7);
        chk(v, 8'h00);
        // period 3 at 1:1 gives a 16-cycle frame, duty 6 ticks
        w(3'h3, 8'h03);
        w(3'h5, 8'h80);
        w(3'h0, 8'h80);
        repeat (80) @(posedge mclk);
        chk(per_q, 8'h10);
        chk(hi_q, 8'h06);
        w(3'h0, 8'h90);
        repeat (80) @(posedge mclk);
        chk(hi_q, 8'h0a);
        w(3'h0, 8'h80);
        w(3'h1, 8'h20);
        repeat (80) @(posedge mclk);
        chk({7'h00, pwm_out_q}, 8'h01);
        r(3'h0);
        chk(v, 8'ha0);
        w(3'h1, 8'h00);
        w(3'h2, 8'h00);
        repeat (80) @(posedge mclk);
        chk({7'h00, pwm_out_q}, 8'h00);
        w(3'h1, 8'h01);
        w(3'h2, 8'h80);
        repeat (43) @(posedge mclk);
        sleep_req <= 1'b1;
        repeat (6) @(posedge mclk);
        r(3'h4);
        t = v;
        repeat (30) @(posedge mclk);
        r(3'h4);
        chk(v, t);
        sleep_req <= 1'b0;
        repeat (80) @(posedge mclk);
        chk(hi_q, 8'h06);
        reset_n <= 1'b0;
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        r(3'h1);
        chk(v, 8'h01);
        r(3'h0);
        chk(v, 8'h00);
        finish_test;
    end
endmodule
